// File: design/alu_branch_execute.sv
// Purpose: execute stage for arithmetic, logic, multiply, compare, skip and branch
// Assumes: caller decodes the instruction, supplies operands, writes back results
// Notes: one instruction at a time; issue is ignored while busy_o is high
//
// Operation
// RQ1 - register add writes sum in one cycle, updates Z C N V H
// RQ2 - add with carry adds carry flag in, one cycle, Z C N V H
// RQ3 - word add immediate on register pair, two cycles, Z C N V S
// RQ4 - word subtract immediate on register pair, two cycles, Z C N V S
// RQ5 - subtract register or constant stores difference, one cycle, Z C N V H
// RQ6 - subtract with borrow also subtracts carry, one cycle, Z C N V H
// RQ7 - AND, OR, XOR one cycle, update Z N V, keep C and H
// RQ8 - set bits ORs mask, clear bits ANDs inverted mask, one cycle
// RQ9 - zero sign test ANDs register with itself, value kept, Z N V
// RQ10 - three multiplies give 16-bit product to low pair, two cycles, Z C
// RQ11 - fractional multiplies shift product left one, two cycles, Z C
// RQ12 - pointer jump loads pc from Z pointer, two cycles, no flags
// RQ13 - pointer call loads pc from Z, saves return, three cycles
// RQ14 - compare skip equal skips next instruction, one to three cycles
// RQ15 - compares set Z N V C H only, no write, one cycle; the code also updates S
// RQ16 - skip on register bit clear or set, one to three cycles
// RQ17 - skip on I/O bit clear or set, one to three cycles
// RQ18 - branch on selected flag adds offset plus one, one or two cycles
// RQ19 - signed branches taken on N xor V, one or two cycles
// RQ20 - unsigned branches taken on carry clear or set
// RQ21 - interrupt branches taken on global interrupt enable bit
// RQ22 - branches on H T V Z C N set or clear, one or two cycles
// RQ23 - relative jump two, relative call three, absolute jump three, call four
// RQ24 - returns pop pc in four cycles, interrupt return sets I
// RQ25 - invert and negate one cycle, increment decrement update Z N V
// RQ26 - clear register XORs itself with Z N V, fill ones no flags
`include "exec_consts.svh"

// ****************************************
// execute unit
// ****************************************
module alu_branch_execute #(
  parameter int PC_W = 16
) (
  input logic clk_i,
  input logic rst_n_i,
  input logic issue_i,
  input exec_pkg::op_e op_i,
  input logic [7:0] a_i,
  input logic [7:0] b_i,
  input logic [15:0] pair_i,
  input logic [2:0] bit_sel_i,
  input logic [7:0] io_val_i,
  input logic [PC_W-1:0] offset_i,
  input logic [PC_W-1:0] target_i,
  input logic [PC_W-1:0] z_ptr_i,
  input logic [PC_W-1:0] stack_pc_i,
  input logic next_long_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] result_o,
  output logic result_we_o,
  output logic [15:0] word_result_o,
  output logic word_we_o,
  output logic [15:0] product_o,
  output logic product_we_o,
  output logic [7:0] flags_o,
  output logic [PC_W-1:0] pc_o,
  output logic push_o,
  output logic [PC_W-1:0] link_addr_o
);
  import exec_pkg::*;

  // wider pc would exceed the pointer pair feeding it
  if (PC_W < 8 || PC_W > 16) begin : g_pc_check
    $error("PC_W must lie between 8 and 16");
  end

  state_e state_r;
  logic [2:0] cnt_r;
  commit_s n_c;
  commit_s pend_r;
  commit_s cm;
  logic [PC_W-1:0] n_pc;
  logic [PC_W-1:0] n_link;
  logic [PC_W-1:0] pend_pc_r;
  logic [PC_W-1:0] pend_link_r;
  logic [PC_W-1:0] cm_pc;
  logic [PC_W-1:0] cm_link;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] pc_rel;
  logic [2:0] n_cyc;
  logic accept;
  logic commit;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [7:0] lres;
  logic [7:0] r;
  logic [8:0] sum9;
  logic cin;
  logic sub;
  logic arith;
  logic keepz;
  logic logic_upd;
  logic vlog;
  logic hv;
  logic vv;
  logic take;
  logic skip;
  logic flag_bit;
  logic c_flag;
  logic n_flag;
  logic v_flag;
  logic [15:0] k6;
  logic [15:0] wres;
  logic [15:0] prod;
  logic mcarry;
  logic mzero;
  logic msa;
  logic msb;
  logic mfrac;

  // ****************************************
  // operand preparation
  // ****************************************
  assign accept = issue_i && (state_r == st_idle);
  assign c_flag = flags_o[`FLAG_C];
  assign n_flag = flags_o[`FLAG_N];
  assign v_flag = flags_o[`FLAG_V];
  assign flag_bit = flags_o[bit_sel_i];
  assign pc_next = PC_W'(pc_o + 1);
  assign pc_rel = PC_W'(pc_o + offset_i + 1);
  // word immediate is six bits wide
  assign k6 = {10'h000, b_i[5:0]};
  assign wres = (op_i == word_subtract_immediate) ? pair_i - k6 : pair_i + k6; // RQ3 RQ4

  assign msa = (op_i == product_signed) || (op_i == product_mixed_sign) ||
               (op_i == fraction_product_signed) || (op_i == fraction_product_mixed);
  assign msb = (op_i == product_signed) || (op_i == fraction_product_signed);
  assign mfrac = (op_i == fraction_product_unsigned) || (op_i == fraction_product_signed) ||
                 (op_i == fraction_product_mixed);

  product_unit product_unit_i (
    .a_i(a_i),
    .b_i(b_i),
    .a_signed_i(msa),
    .b_signed_i(msb),
    .frac_i(mfrac),
    .product_o(prod),
    .carry_o(mcarry),
    .zero_o(mzero)
  );

  // ****************************************
  // decode and result computation
  // ****************************************
  always_comb begin
    n_c = '0;
    n_c.res = a_i;
    n_c.word = wres;
    n_c.prod = prod;
    n_c.flags = flags_o;
    n_pc = pc_next;
    n_link = pc_next;
    n_cyc = `CYC_1;
    opa = a_i;
    opb = b_i;
    cin = 1'b0;
    sub = 1'b0;
    arith = 1'b0;
    keepz = 1'b0;
    logic_upd = 1'b0;
    lres = a_i;
    vlog = 1'b0;
    take = 1'b0;
    skip = 1'b0;
    case (op_i)
      add_regs: begin
        arith = 1'b1; // RQ1
        n_c.res_we = 1'b1;
      end
      add_with_carry: begin
        arith = 1'b1;
        cin = c_flag; // RQ2
        n_c.res_we = 1'b1;
      end
      subtract_regs, subtract_constant: begin
        arith = 1'b1;
        sub = 1'b1; // RQ5
        n_c.res_we = 1'b1;
      end
      subtract_with_borrow, subtract_constant_with_borrow: begin
        arith = 1'b1;
        sub = 1'b1;
        cin = c_flag; // RQ6
        keepz = 1'b1;
        n_c.res_we = 1'b1;
      end
      negate_value: begin
        arith = 1'b1;
        sub = 1'b1;
        opa = 8'h00; // RQ25
        opb = a_i;
        n_c.res_we = 1'b1;
      end
      compare_regs, compare_immediate: begin
        arith = 1'b1; // RQ15
        sub = 1'b1;
      end
      compare_with_borrow: begin
        arith = 1'b1; // RQ15
        sub = 1'b1;
        cin = c_flag;
        keepz = 1'b1;
      end
      and_regs, and_with_constant: begin
        logic_upd = 1'b1; // RQ7
        lres = a_i & b_i;
      end
      or_regs, or_with_constant: begin
        logic_upd = 1'b1; // RQ7
        lres = a_i | b_i;
      end
      exclusive_or_regs: begin
        logic_upd = 1'b1; // RQ7
        lres = a_i ^ b_i;
      end
      set_bits_masked: begin
        logic_upd = 1'b1;
        lres = a_i | b_i; // RQ8
      end
      clear_bits_masked: begin
        logic_upd = 1'b1;
        lres = a_i & (`ALL_ONES - b_i); // RQ8
      end
      zero_sign_test: begin
        logic_upd = 1'b1;
        lres = a_i & a_i; // RQ9
      end
      zero_register: begin
        logic_upd = 1'b1;
        lres = a_i ^ a_i; // RQ26
      end
      invert_all_bits: begin
        logic_upd = 1'b1;
        lres = `ALL_ONES - a_i; // RQ25
        n_c.flags[`FLAG_C] = 1'b1;
      end
      plus_one: begin
        logic_upd = 1'b1;
        lres = a_i + 8'h01; // RQ25
        vlog = (a_i == 8'h7f);
      end
      minus_one: begin
        logic_upd = 1'b1;
        lres = a_i - 8'h01; // RQ25
        vlog = (a_i == 8'h80);
      end
      fill_ones: begin
        n_c.res = `ALL_ONES; // RQ26
        n_c.res_we = 1'b1;
      end
      word_add_immediate: begin
        n_cyc = `CYC_2; // RQ3
        n_c.word_we = 1'b1;
        n_c.flags[`FLAG_V] = ~pair_i[15] & wres[15];
        n_c.flags[`FLAG_C] = ~wres[15] & pair_i[15];
        n_c.flags[`FLAG_N] = wres[15];
        n_c.flags[`FLAG_Z] = (wres == 16'h0000);
        n_c.flags[`FLAG_S] = wres[15] ^ (~pair_i[15] & wres[15]);
      end
      word_subtract_immediate: begin
        n_cyc = `CYC_2; // RQ4
        n_c.word_we = 1'b1;
        n_c.flags[`FLAG_V] = pair_i[15] & ~wres[15];
        n_c.flags[`FLAG_C] = wres[15] & ~pair_i[15];
        n_c.flags[`FLAG_N] = wres[15];
        n_c.flags[`FLAG_Z] = (wres == 16'h0000);
        n_c.flags[`FLAG_S] = wres[15] ^ (pair_i[15] & ~wres[15]);
      end
      product_unsigned, product_signed, product_mixed_sign,
      fraction_product_unsigned, fraction_product_signed, fraction_product_mixed: begin
        n_cyc = `CYC_2; // RQ10 RQ11
        n_c.prod_we = 1'b1;
        n_c.flags[`FLAG_C] = mcarry;
        n_c.flags[`FLAG_Z] = mzero;
      end
      relative_jump: begin
        n_cyc = `CYC_2; // RQ23
        n_pc = pc_rel;
      end
      relative_subroutine_call: begin
        n_cyc = `CYC_3; // RQ23
        n_pc = pc_rel;
        n_c.push = 1'b1;
      end
      absolute_jump: begin
        n_cyc = `CYC_3; // RQ23
        n_pc = target_i;
      end
      absolute_subroutine_call: begin
        n_cyc = `CYC_4; // RQ23
        n_pc = target_i;
        n_link = PC_W'(pc_o + 2);
        n_c.push = 1'b1;
      end
      pointer_jump: begin
        n_cyc = `CYC_2; // RQ12
        n_pc = z_ptr_i;
      end
      pointer_subroutine_call: begin
        n_cyc = `CYC_3; // RQ13
        n_pc = z_ptr_i;
        n_c.push = 1'b1;
      end
      subroutine_exit: begin
        n_cyc = `CYC_4; // RQ24
        n_pc = stack_pc_i;
      end
      interrupt_exit: begin
        n_cyc = `CYC_4; // RQ24
        n_pc = stack_pc_i;
        n_c.flags[`FLAG_I] = 1'b1;
      end
      compare_skip_equal: skip = (a_i == b_i); // RQ14
      skip_reg_bit_clear: skip = ~a_i[bit_sel_i]; // RQ16
      skip_reg_bit_set: skip = a_i[bit_sel_i]; // RQ16
      skip_io_bit_clear: skip = ~io_val_i[bit_sel_i]; // RQ17
      skip_io_bit_set: skip = io_val_i[bit_sel_i]; // RQ17
      branch_flag_set: take = flag_bit; // RQ18 RQ22
      branch_flag_clear: take = ~flag_bit; // RQ18 RQ22
      branch_signed_ge: take = ~(n_flag ^ v_flag); // RQ19
      branch_signed_lt: take = n_flag ^ v_flag; // RQ19
      branch_unsigned_ge: take = ~c_flag; // RQ20
      branch_unsigned_lt: take = c_flag; // RQ20
      branch_irq_enabled: take = flags_o[`FLAG_I]; // RQ21
      branch_irq_disabled: take = ~flags_o[`FLAG_I]; // RQ21
      branch_half_carry_set: take = flags_o[`FLAG_H]; // RQ22
      branch_transfer_bit_set: take = flags_o[`FLAG_T]; // RQ22
      branch_overflow_set: take = v_flag; // RQ22
      default: begin
      end
    endcase
    // borrow out of bit 8 doubles as the carry flag for subtracts
    if (sub) begin
      sum9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
    end else begin
      sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    end
    r = sum9[7:0];
    if (sub) begin
      hv = (~opa[3] & opb[3]) | (opb[3] & r[3]) | (r[3] & ~opa[3]);
      vv = (opa[7] & ~opb[7] & ~r[7]) | (~opa[7] & opb[7] & r[7]);
    end else begin
      hv = (opa[3] & opb[3]) | (opb[3] & ~r[3]) | (~r[3] & opa[3]);
      vv = (opa[7] & opb[7] & ~r[7]) | (~opa[7] & ~opb[7] & r[7]);
    end
    if (arith) begin
      n_c.res = r; // RQ1 RQ2 RQ5 RQ6
      n_c.flags[`FLAG_C] = sum9[8];
      // borrow forms keep Z only if it was already set, for multi-byte chains
      n_c.flags[`FLAG_Z] = keepz ? ((r == 8'h00) & flags_o[`FLAG_Z]) : (r == 8'h00);
      n_c.flags[`FLAG_N] = r[7];
      n_c.flags[`FLAG_V] = vv;
      n_c.flags[`FLAG_S] = r[7] ^ vv;
      n_c.flags[`FLAG_H] = hv;
    end
    if (logic_upd) begin
      n_c.res = lres; // RQ7 RQ8 RQ9
      n_c.res_we = 1'b1;
      n_c.flags[`FLAG_Z] = (lres == 8'h00);
      n_c.flags[`FLAG_N] = lres[7];
      n_c.flags[`FLAG_V] = vlog;
      n_c.flags[`FLAG_S] = lres[7] ^ vlog;
    end
    if (take) begin
      n_pc = pc_rel; // RQ18
      n_cyc = `CYC_2;
    end
    if (skip) begin
      n_pc = next_long_i ? PC_W'(pc_o + `SKIP_LONG) : PC_W'(pc_o + `SKIP_SHORT); // RQ14
      n_cyc = next_long_i ? `CYC_3 : `CYC_2;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  assign commit = (accept && (n_cyc == `CYC_1)) || ((state_r == st_busy) && (cnt_r == 3'h1));
  assign cm = (state_r == st_idle) ? n_c : pend_r;
  assign cm_pc = (state_r == st_idle) ? n_pc : pend_pc_r;
  assign cm_link = (state_r == st_idle) ? n_link : pend_link_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= st_idle;
      cnt_r <= 3'h0;
      busy_o <= 1'b0;
    end else begin
      case (state_r)
        st_idle: begin
          if (accept && (n_cyc != `CYC_1)) begin
            state_r <= st_busy;
            cnt_r <= n_cyc - `CYC_1;
            busy_o <= 1'b1;
          end
        end
        st_busy: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h1) begin
            state_r <= st_idle;
            busy_o <= 1'b0;
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // results are computed and captured at issue so the caller may move on
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= '0;
      pend_pc_r <= '0;
      pend_link_r <= '0;
    end else if (accept) begin
      pend_r <= n_c;
      pend_pc_r <= n_pc;
      pend_link_r <= n_link;
    end
  end

  // ****************************************
  // write-back
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      result_we_o <= 1'b0;
      word_we_o <= 1'b0;
      product_we_o <= 1'b0;
      push_o <= 1'b0;
    end else begin
      done_o <= commit;
      result_we_o <= commit && cm.res_we;
      word_we_o <= commit && cm.word_we;
      product_we_o <= commit && cm.prod_we; // RQ10
      push_o <= commit && cm.push; // RQ13
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= 8'h00;
      word_result_o <= 16'h0000;
      product_o <= 16'h0000;
      link_addr_o <= '0;
    end else if (commit) begin
      result_o <= cm.res;
      word_result_o <= cm.word;
      product_o <= cm.prod;
      link_addr_o <= cm_link;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= `FLAGS_RESET;
      pc_o <= PC_W'(`PC_RESET);
    end else if (commit) begin
      flags_o <= cm.flags;
      pc_o <= cm_pc;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence stall_seq;
    busy_o && !done_o;
  endsequence

  add_sum_a: assert property (accept && op_i == add_regs |=> done_o && result_we_o && // RQ1
    result_o == 8'($past(a_i) + $past(b_i))) else $error("add result wrong");
  carry_add_a: assert property (accept && op_i == add_with_carry |=> // RQ2
    result_o == 8'($past(a_i) + $past(b_i) + {7'h00, $past(c_flag)}))
    else $error("carry add wrong");
  word_add_a: assert property (accept && op_i == word_add_immediate |=> stall_seq ##1 // RQ3
    (done_o && word_we_o && word_result_o == 16'($past(pair_i, 2) + $past(k6, 2))))
    else $error("word add wrong");
  word_sub_a: assert property (accept && op_i == word_subtract_immediate |=> stall_seq ##1 // RQ4
    (word_we_o && word_result_o == 16'($past(pair_i, 2) - $past(k6, 2))))
    else $error("word subtract wrong");
  sub_diff_a: assert property (accept && op_i == subtract_constant |=> result_we_o && // RQ5
    result_o == 8'($past(a_i) - $past(b_i))) else $error("subtract wrong");
  borrow_sub_a: assert property (accept && op_i == subtract_with_borrow |=> // RQ6
    result_o == 8'($past(a_i) - $past(b_i) - {7'h00, $past(c_flag)}))
    else $error("borrow subtract wrong");
  logic_keep_a: assert property (accept && op_i inside {and_regs, or_regs, exclusive_or_regs} // RQ7
    |=> $stable(c_flag) && !v_flag && done_o) else $error("logic op flags wrong");
  mask_clear_a: assert property (accept && op_i == clear_bits_masked |=> // RQ8
    result_o == ($past(a_i) & ~$past(b_i))) else $error("mask clear wrong");
  test_keep_a: assert property (accept && op_i == zero_sign_test |=> // RQ9
    result_o == $past(a_i) && n_flag == result_o[7]) else $error("test changed value");
  product_place_a: assert property (accept && op_i == product_unsigned |=> stall_seq ##1 // RQ10
    (product_we_o && product_o == ({8'h00, $past(a_i, 2)} * {8'h00, $past(b_i, 2)})))
    else $error("product wrong");
  frac_shift_a: assert property (accept && op_i == fraction_product_unsigned |=> stall_seq ##1 // RQ11
    (product_o == 16'(({8'h00, $past(a_i, 2)} * {8'h00, $past(b_i, 2)}) << 1)))
    else $error("fraction product wrong");
  ptr_jump_a: assert property (accept && op_i == pointer_jump |=> stall_seq ##1 // RQ12
    (done_o && pc_o == $past(z_ptr_i, 2) && $stable(flags_o))) else $error("pointer jump wrong");
  ptr_call_a: assert property (accept && op_i == pointer_subroutine_call |=> stall_seq[*2] ##1 // RQ13
    (push_o && pc_o == $past(z_ptr_i, 3) && link_addr_o == PC_W'($past(pc_o, 3) + 1)))
    else $error("pointer call wrong");
  skip_equal_a: assert property (accept && op_i == compare_skip_equal && a_i == b_i && // RQ14
    !next_long_i |=> stall_seq ##1 (done_o && pc_o == PC_W'($past(pc_o, 2) + 2)))
    else $error("skip equal wrong");
  cmp_nowrite_a: assert property (accept && op_i inside {compare_regs, compare_immediate} // RQ15
    |=> done_o && !result_we_o) else $error("compare wrote a register");
  branch_taken_a: assert property (accept && op_i == branch_flag_set && flag_bit |=> // RQ18
    stall_seq ##1 (done_o && pc_o == PC_W'($past(pc_o, 2) + $past(offset_i, 2) + 1)))
    else $error("taken branch wrong");
  branch_idle_a: assert property (accept && op_i == branch_signed_ge && (n_flag ^ v_flag) // RQ19
    |=> done_o && pc_o == PC_W'($past(pc_o) + 1)) else $error("untaken branch wrong");
  irq_exit_a: assert property (accept && op_i == interrupt_exit |=> stall_seq[*3] ##1 // RQ24
    (done_o && pc_o == $past(stack_pc_i, 4) && flags_o[`FLAG_I])) else $error("return wrong");
endmodule

// File: design/product_unit.sv
// Purpose: 8x8 multiplier with signed, mixed and fractional forms
// Assumes: purely combinational, sampled by the caller
// Notes: 9-bit sign extension covers all three sign forms at once

// ****************************************
// product unit
// ****************************************
module product_unit (
  input logic [7:0] a_i,
  input logic [7:0] b_i,
  input logic a_signed_i,
  input logic b_signed_i,
  input logic frac_i,
  output logic [15:0] product_o,
  output logic carry_o,
  output logic zero_o
);
  logic signed [8:0] ext_a;
  logic signed [8:0] ext_b;
  logic signed [17:0] full;
  logic [15:0] raw;

  assign ext_a = {a_signed_i & a_i[7], a_i};
  assign ext_b = {b_signed_i & b_i[7], b_i};
  assign full = ext_a * ext_b;
  assign raw = full[15:0];
  // carry is the top bit before any shift
  assign carry_o = raw[15]; // RQ10
  assign product_o = frac_i ? {raw[14:0], 1'b0} : raw; // RQ11
  assign zero_o = (product_o == 16'h0000);
endmodule

// File: include/exec_consts.svh
// Purpose: shared constants of the execute block
// Assumes: included by its bare name before the module
// Notes: flag positions follow the status byte layout
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// ****************************************
// status byte bit positions
// ****************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ****************************************
// reset values
// ****************************************
`define FLAGS_RESET 8'h00
`define PC_RESET 0

// ****************************************
// cycle counts and fixed operands
// ****************************************
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4
`define SKIP_SHORT 2
`define SKIP_LONG 3
`define ALL_ONES 8'hff

`endif

// File: include/exec_pkg.sv
// Purpose: types of the execute block
// Assumes: nothing
// Notes: operation list is the decoded instruction handed in
package exec_pkg;

  // ****************************************
  // decoded operations
  // ****************************************
  typedef enum logic [5:0] {
    add_regs, add_with_carry, word_add_immediate, word_subtract_immediate,
    subtract_regs, subtract_constant, subtract_with_borrow, subtract_constant_with_borrow,
    and_regs, and_with_constant, or_regs, or_with_constant, exclusive_or_regs,
    invert_all_bits, negate_value, set_bits_masked, clear_bits_masked,
    plus_one, minus_one, zero_sign_test, zero_register, fill_ones,
    product_unsigned, product_signed, product_mixed_sign,
    fraction_product_unsigned, fraction_product_signed, fraction_product_mixed,
    relative_jump, pointer_jump, absolute_jump,
    relative_subroutine_call, pointer_subroutine_call, absolute_subroutine_call,
    subroutine_exit, interrupt_exit,
    compare_skip_equal, compare_regs, compare_with_borrow, compare_immediate,
    skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
    branch_flag_set, branch_flag_clear, branch_signed_ge, branch_signed_lt,
    branch_unsigned_ge, branch_unsigned_lt, branch_irq_enabled, branch_irq_disabled,
    branch_half_carry_set, branch_transfer_bit_set, branch_overflow_set,
    no_operation
  } op_e;

  typedef enum logic {st_idle, st_busy} state_e;

  // ****************************************
  // everything written back at commit except pc and link
  // ****************************************
  typedef struct packed {
    logic [7:0] res;
    logic res_we;
    logic [15:0] word;
    logic word_we;
    logic [15:0] prod;
    logic prod_we;
    logic [7:0] flags;
    logic push;
  } commit_s;

endpackage

// File: tb/alu_branch_execute_tb.sv
// Purpose: self-checking bench for the execute unit
// Assumes: default PC_W of 16, one op in flight at a time
// Notes: notes queued at issue, checked at negedge while done_o is high
module alu_branch_execute_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, issue_i = 1'b0, next_long_i = 1'b0;
  op_e op_i = no_operation;
  logic [7:0] a_i = 8'h00, b_i = 8'h00, io_val_i = 8'h00, a, b;
  logic [2:0] bit_sel_i = 3'h0;
  logic [15:0] pair_i = 16'h0000, offset_i = 16'h0000, target_i = 16'h0000;
  logic [15:0] z_ptr_i = 16'h0000, stack_pc_i = 16'h0000, x = 16'he658, pc_e = 16'h0000, p, sv;
  logic busy_o, done_o, result_we_o, word_we_o, product_we_o, push_o, c;
  logic [7:0] result_o, flags_o;
  logic [15:0] word_result_o, product_o, pc_o, link_addr_o;
  logic [8:0] s;
  logic [34:0] q[$], e;
  int n_fail = 0, num_checks = 0;
  always #25 clk_i = ~clk_i;
  alu_branch_execute alu_branch_execute_i (.clk_i, .rst_n_i, .issue_i, .op_i, .a_i, .b_i,
    .pair_i, .bit_sel_i, .io_val_i, .offset_i, .target_i, .z_ptr_i, .stack_pc_i, .next_long_i,
    .busy_o, .done_o, .result_o, .result_we_o, .word_result_o, .word_we_o, .product_o,
    .product_we_o, .flags_o, .pc_o, .push_o, .link_addr_o);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] rnd();
    x = x ^ (x << 7);
    x = x ^ (x >> 9);
    x = x ^ (x << 8);
    return x;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // kind 0 byte, 1 product, 2 pc, 3 flags, 4 word, 5 link, 6 strobes; mask picks bits
  task automatic note(input logic [2:0] k, input logic [15:0] m, input logic [15:0] v);
    q.push_back({k, m, v});
  endtask
  task automatic run(input op_e op, input logic [15:0] npc);
    int k;
    note(3'h2, 16'hffff, npc);
    op_i <= op;
    issue_i <= 1'b1;
    pair_i <= x;
    target_i <= x;
    @(posedge clk_i);
    issue_i <= 1'b0;
    for (k = 0; k < 8 && done_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 8) begin
      n_fail++;
      wrap_up();
    end
    pc_e = npc;
  endtask
  // negedge sampling keeps the monitor clear of the edge that launches the next op
  always @(negedge clk_i) if (done_o === 1'b1) while (q.size() > 0) begin
    e = q.pop_front();
    case (e[34:32])
      3'h0: sv = {8'h00, result_o};
      3'h1: sv = product_o;
      3'h2: sv = pc_o;
      3'h3: sv = {8'h00, flags_o};
      3'h4: sv = word_result_o;
      3'h5: sv = link_addr_o;
      default: sv = {11'h000, busy_o, result_we_o, word_we_o, product_we_o, push_o};
    endcase
    check(sv & e[31:16], e[15:0]);
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      a = 8'(rnd()); b = 8'(rnd()); a_i <= a; b_i <= b; s = a + b;
      note(3'h0, 16'h00ff, {8'h00, s[7:0]});
      note(3'h3, 16'h0003, {14'h0, s[7:0] == 8'h00, s[8]});
      note(3'h6, 16'h001f, 16'h0008);
      run(add_regs, pc_e + 16'h0001);
      c = s[8]; a = 8'(rnd()); b = 8'(rnd()); a_i <= a; b_i <= b; s = a + b + c;
      note(3'h0, 16'h00ff, {8'h00, s[7:0]});
      run(add_with_carry, pc_e + 16'h0001);
      // run drives pair_i from the current seed, so the sum is known here
      note(3'h4, 16'hffff, x + {10'h000, b[5:0]});
      note(3'h6, 16'h001f, 16'h0004);
      run(word_add_immediate, pc_e + 16'h0001);
      a = 8'(rnd()); b = 8'(rnd()); a_i <= a; b_i <= b; s = {1'b0, a} - {1'b0, b};
      note(3'h3, 16'h0003, {14'h0, s[7:0] == 8'h00, s[8]});
      run(subtract_regs, pc_e + 16'h0001);
      c = s[8]; a = 8'(rnd()); b = 8'(rnd()); a_i <= a; b_i <= b;
      note(3'h0, 16'h00ff, {8'h00, a & b});
      note(3'h3, 16'h0003, {14'h0, (a & b) == 8'h00, c});
      run(and_regs, pc_e + 16'h0001);
      note(3'h0, 16'h00ff, {8'h00, a & ~b});
      run(clear_bits_masked, pc_e + 16'h0001);
      p = a * b;
      note(3'h1, 16'hffff, p);
      note(3'h6, 16'h001f, 16'h0002);
      run(product_unsigned, pc_e + 16'h0001);
      note(3'h1, 16'hffff, p << 1);
      run(fraction_product_unsigned, pc_e + 16'h0001);
      a = 8'(rnd()); a_i <= a; c = a < b;
      note(3'h3, 16'h0003, {14'h0, a == b, c});
      note(3'h6, 16'h001f, 16'h0000);
      run(compare_regs, pc_e + 16'h0001);
      p = rnd(); offset_i <= p;
      run(branch_unsigned_lt, c ? pc_e + p + 16'h0001 : pc_e + 16'h0001);
      p = rnd(); z_ptr_i <= p;
      run(pointer_jump, p);
      note(3'h5, 16'hffff, pc_e + 16'h0001);
      note(3'h6, 16'h001f, 16'h0001);
      p = rnd(); z_ptr_i <= p;
      run(pointer_subroutine_call, p);
      note(3'h3, 16'h0080, 16'h0080);
      p = rnd(); stack_pc_i <= p;
      run(interrupt_exit, p);
      // the interrupt enable bit is now set, so this branch is always taken
      p = rnd(); offset_i <= p; bit_sel_i <= 3'h7;
      run(branch_flag_set, pc_e + p + 16'h0001);
      b_i <= a; next_long_i <= p[0];
      run(compare_skip_equal, p[0] ? pc_e + 16'h0003 : pc_e + 16'h0002);
    end
    wrap_up();
  end
endmodule
